/* rtl/agrc_consts.svh */
// Register offsets, field positions, reset values, monitor codes, scale shift and clock rate for the gain/rate calibration bank
`ifndef AGRC_CONSTS_SVH
`define AGRC_CONSTS_SVH

`define AGRC_ADDR_W           4
`define AGRC_OFF_GAIN_RATE    4'h3
`define AGRC_OFF_OFS_LOW      4'h4
`define AGRC_OFF_OFS_MID      4'h5
`define AGRC_OFF_OFS_HIGH     4'h6
`define AGRC_OFF_SCL_LOW      4'h7
`define AGRC_OFF_SCL_MID      4'h8
`define AGRC_OFF_SCL_HIGH     4'h9
`define AGRC_OFF_MONITOR      4'hB

`define AGRC_RST_GAIN_RATE    8'h00
`define AGRC_RST_OFS_BYTE     8'h00
`define AGRC_RST_SCL_LOW      8'h00
`define AGRC_RST_SCL_MID      8'h00
`define AGRC_RST_SCL_HIGH     8'h40
`define AGRC_RST_MONITOR      3'h0

`define AGRC_GAIN_MSB         6
`define AGRC_GAIN_LSB         4
`define AGRC_RATE_MSB         3
`define AGRC_RATE_LSB         0
`define AGRC_GAIN_RATE_MASK   8'h7F

`define AGRC_MON_GAIN_CAL     3'h2
`define AGRC_MON_TEMP         3'h3

`define AGRC_SCALE_ONE_SHIFT  22
`define AGRC_CLK_HZ           100000000

`endif

/* rtl/agrc_pkg.sv */
// Types shared by the gain/rate calibration bank
package agrc_pkg;

	typedef struct packed
	{
		logic [2:0] gain_select;
		logic [3:0] output_rate_select;
	} agrc_ctrl_t;

	typedef struct packed
	{
		logic        valid;
		logic [23:0] data;
	} agrc_sample_t;

	typedef enum logic [2:0]
	{
		AGRC_IDLE = 3'b001,
		AGRC_SUB  = 3'b010,
		AGRC_MUL  = 3'b100
	} agrc_state_t;

endpackage : agrc_pkg

/* rtl/agrc_rate_div.sv */
// Output data rate divider: one-cycle sample strobe at the selected rate
`timescale 1ns/1ps
`include "agrc_consts.svh"

module agrc_rate_div #(
	parameter int CLK_HZ = `AGRC_CLK_HZ
) (
	// Clock and reset
	input  wire logic       sys_clk_in,
	input  wire logic       rst_in,
	// Rate code
	input  wire logic [3:0] output_rate_select_in,
	// Sample strobe
	output logic            sample_tick_out
);

	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	logic [31:0] period;
	logic        tick_d;

	// Codes 9 to 15 all give the top rate
	always_comb
	begin
		unique case (output_rate_select_in)
			4'h0: period = 32'(CLK_HZ / 5);
			4'h1: period = 32'(CLK_HZ / 10);
			4'h2: period = 32'(CLK_HZ / 20);
			4'h3: period = 32'(CLK_HZ / 40);
			4'h4: period = 32'(CLK_HZ / 80);
			4'h5: period = 32'(CLK_HZ / 160);
			4'h6: period = 32'(CLK_HZ / 320);
			4'h7: period = 32'(CLK_HZ / 640);
			4'h8: period = 32'(CLK_HZ / 1000);
			default: period = 32'(CLK_HZ / 2000);
		endcase
	end

	// Rate restarts cleanly if the period shrinks below the count
	always_comb
	begin
		tick_d = 1'b0;
		cnt_d  = cnt_q + 32'h1;
		if (cnt_q >= period - 32'h1)
		begin
			cnt_d  = 32'h0;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			cnt_q           <= 32'h0;
			sample_tick_out <= 1'b0;
		end
		else
		begin
			cnt_q           <= cnt_d;
			sample_tick_out <= tick_d;
		end
	end

endmodule : agrc_rate_div

/* rtl/agrc_gain_stage.sv */
// Gain stage: applies two to the power of the effective gain code
`timescale 1ns/1ps

module agrc_gain_stage (
	// Clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	// Control
	input  wire logic [2:0]  gain_code_in,
	// Data
	input  wire logic        raw_valid_in,
	input  wire logic [23:0] raw_in,
	output logic             amp_valid_out,
	output logic [23:0]      amp_out
);

	logic [30:0] wide;

	// Gain is 1 << code, 1 to 128
	always_comb
	begin
		wide = 31'($signed(raw_in)) <<< gain_code_in;
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			amp_valid_out <= 1'b0;
			amp_out       <= 24'h0;
		end
		else
		begin
			amp_valid_out <= raw_valid_in;
			if ($signed(wide) > 31'sh7FFFFF)
				amp_out <= 24'h7FFFFF;
			else if ($signed(wide) < -31'sh800000)
				amp_out <= 24'h800000;
			else
				amp_out <= wide[23:0];
		end
	end

endmodule : agrc_gain_stage

/* rtl/agrc_regs.sv */
// Gain, rate and calibration register bank with offset/scale correction path
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "agrc_consts.svh"

module agrc_regs #(
	parameter int CLK_HZ = `AGRC_CLK_HZ
) (
	// Clock and reset
	input  wire logic                     sys_clk_in,
	input  wire logic                     rst_in,
	// Register port
	input  wire logic [`AGRC_ADDR_W-1:0]  reg_addr_in,
	input  wire logic [7:0]               reg_wdata_in,
	input  wire logic                     reg_wr_in,
	input  wire logic                     reg_rd_in,
	output logic [7:0]                    reg_rdata_out,
	// Raw conversion results
	input  wire logic                     raw_valid_in,
	input  wire logic [23:0]              raw_in,
	// Conversion control
	output logic [2:0]                    eff_gain_out,
	output logic                          sample_tick_out,
	// Corrected results
	output logic                          result_valid_out,
	output logic [23:0]                   result_out
);

	////////////////////////////////////////////////////////////////////////////////
	// Register file

	agrc_pkg::agrc_ctrl_t ctrl_q;
	agrc_pkg::agrc_ctrl_t ctrl_d;
	logic [23:0]          ofs_q;
	logic [23:0]          ofs_d;
	logic [23:0]          scl_q;
	logic [23:0]          scl_d;
	logic [2:0]           mon_q;
	logic [2:0]           mon_d;
	logic [7:0]           rdata_d;
	logic [7:0]           gr_byte;

	assign gr_byte = {1'b0, ctrl_q.gain_select, ctrl_q.output_rate_select};

	always_comb
	begin
		ctrl_d = ctrl_q;
		ofs_d  = ofs_q;
		scl_d  = scl_q;
		mon_d  = mon_q;
		if (reg_wr_in)
		begin
			unique case (reg_addr_in)
				`AGRC_OFF_GAIN_RATE:
				begin
					// Bit 7 discarded
					ctrl_d.gain_select        = reg_wdata_in[`AGRC_GAIN_MSB:`AGRC_GAIN_LSB];
					ctrl_d.output_rate_select = reg_wdata_in[`AGRC_RATE_MSB:`AGRC_RATE_LSB];
				end
				`AGRC_OFF_OFS_LOW:  ofs_d[7:0]   = reg_wdata_in;
				`AGRC_OFF_OFS_MID:  ofs_d[15:8]  = reg_wdata_in;
				`AGRC_OFF_OFS_HIGH: ofs_d[23:16] = reg_wdata_in;
				`AGRC_OFF_SCL_LOW:  scl_d[7:0]   = reg_wdata_in;
				`AGRC_OFF_SCL_MID:  scl_d[15:8]  = reg_wdata_in;
				`AGRC_OFF_SCL_HIGH: scl_d[23:16] = reg_wdata_in;
				`AGRC_OFF_MONITOR:  mon_d        = reg_wdata_in[2:0];
				default: ;
			endcase
		end
	end

	// Unmapped reads return zero
	always_comb
	begin
		rdata_d = 8'h00;
		if (reg_rd_in)
		begin
			unique case (reg_addr_in)
				`AGRC_OFF_GAIN_RATE: rdata_d = gr_byte;
				`AGRC_OFF_OFS_LOW:   rdata_d = ofs_q[7:0];
				`AGRC_OFF_OFS_MID:   rdata_d = ofs_q[15:8];
				`AGRC_OFF_OFS_HIGH:  rdata_d = ofs_q[23:16];
				`AGRC_OFF_SCL_LOW:   rdata_d = scl_q[7:0];
				`AGRC_OFF_SCL_MID:   rdata_d = scl_q[15:8];
				`AGRC_OFF_SCL_HIGH:  rdata_d = scl_q[23:16];
				`AGRC_OFF_MONITOR:   rdata_d = {5'h00, mon_q};
				default:             rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			ctrl_q        <= agrc_pkg::agrc_ctrl_t'(7'(`AGRC_RST_GAIN_RATE & `AGRC_GAIN_RATE_MASK));
			ofs_q         <= {3{`AGRC_RST_OFS_BYTE}};
			scl_q         <= {`AGRC_RST_SCL_HIGH, `AGRC_RST_SCL_MID, `AGRC_RST_SCL_LOW};
			mon_q         <= `AGRC_RST_MONITOR;
			reg_rdata_out <= 8'h00;
		end
		else
		begin
			ctrl_q        <= ctrl_d;
			ofs_q         <= ofs_d;
			scl_q         <= scl_d;
			mon_q         <= mon_d;
			reg_rdata_out <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Gain override and rate divider

	logic [2:0] eff_gain_d;

	// Gain calibration and temperature monitors force unity gain
	always_comb
	begin
		if (mon_q == `AGRC_MON_GAIN_CAL || mon_q == `AGRC_MON_TEMP)
			eff_gain_d = 3'h0;
		else
			eff_gain_d = ctrl_q.gain_select;
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
			eff_gain_out <= 3'h0;
		else
			eff_gain_out <= eff_gain_d;
	end

	logic tick;

	agrc_rate_div #(
		.CLK_HZ (CLK_HZ)
	) u_rate (
		.sys_clk_in            (sys_clk_in),
		.rst_in                (rst_in),
		.output_rate_select_in (ctrl_q.output_rate_select),
		.sample_tick_out       (tick)
	);

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
			sample_tick_out <= 1'b0;
		else
			sample_tick_out <= tick;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Gain stage and correction path

	logic        amp_valid;
	logic [23:0] amp;

	agrc_gain_stage u_gain (
		.sys_clk_in    (sys_clk_in),
		.rst_in        (rst_in),
		.gain_code_in  (eff_gain_out),
		.raw_valid_in  (raw_valid_in),
		.raw_in        (raw_in),
		.amp_valid_out (amp_valid),
		.amp_out       (amp)
	);

	agrc_pkg::agrc_state_t st_q;
	agrc_pkg::agrc_state_t st_d;
	logic signed [24:0]    diff_q;
	logic signed [24:0]    diff_d;
	logic [23:0]           res_d;
	logic                  rv_d;
	logic signed [49:0]    prod;
	logic signed [49:0]    quo;

	// Result = (amp - ofs) * scl / 2^22
	assign prod = 50'(diff_q) * $signed({1'b0, scl_q});
	assign quo  = prod >>> `AGRC_SCALE_ONE_SHIFT;

	always_comb
	begin
		st_d   = st_q;
		diff_d = diff_q;
		res_d  = result_out;
		rv_d   = 1'b0;
		unique case (st_q)
			agrc_pkg::AGRC_IDLE:
				if (amp_valid)
				begin
					// Full 24-bit subtract, low byte gives sub-step correction
					diff_d = $signed({amp[23], amp}) - $signed({ofs_q[23], ofs_q});
					st_d   = agrc_pkg::AGRC_MUL;
				end
			agrc_pkg::AGRC_MUL:
			begin
				if (quo > 50'sh7FFFFF)
					res_d = 24'h7FFFFF;
				else if (quo < -50'sh800000)
					res_d = 24'h800000;
				else
					res_d = quo[23:0];
				rv_d = 1'b1;
				st_d = agrc_pkg::AGRC_IDLE;
			end
			agrc_pkg::AGRC_SUB: st_d = agrc_pkg::AGRC_IDLE;
			default: st_d = agrc_pkg::AGRC_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			st_q             <= agrc_pkg::AGRC_IDLE;
			diff_q           <= 25'sh0;
			result_out       <= 24'h0;
			result_valid_out <= 1'b0;
		end
		else
		begin
			st_q             <= st_d;
			diff_q           <= diff_d;
			result_out       <= res_d;
			result_valid_out <= rv_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	property p_rsvd_zero;
		@(posedge sys_clk_in) disable iff (rst_in)
		reg_rd_in && reg_addr_in == `AGRC_OFF_GAIN_RATE |=> !reg_rdata_out[7];
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("gain/rate bit 7 read nonzero");

	property p_gr_write;
		@(posedge sys_clk_in) disable iff (rst_in)
		reg_wr_in && reg_addr_in == `AGRC_OFF_GAIN_RATE |=>
			ctrl_q.gain_select == $past(reg_wdata_in[6:4]) && ctrl_q.output_rate_select == $past(reg_wdata_in[3:0]);
	endproperty
	a_gr_write: assert property (p_gr_write) else $error("gain/rate write not stored");

	property p_reset_vals;
		@(posedge sys_clk_in)
		$past(rst_in) |-> gr_byte == 8'h00 && ofs_q == 24'h0 && scl_q == 24'h400000;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

	property p_ofs_rw;
		@(posedge sys_clk_in) disable iff (rst_in)
		reg_wr_in && reg_addr_in == `AGRC_OFF_OFS_HIGH ##1 reg_rd_in && reg_addr_in == `AGRC_OFF_OFS_HIGH && !reg_wr_in
			|=> reg_rdata_out == $past(reg_wdata_in, 2);
	endproperty
	a_ofs_rw: assert property (p_ofs_rw) else $error("offset high byte readback wrong");

	property p_scl_rw;
		@(posedge sys_clk_in) disable iff (rst_in)
		reg_rd_in && reg_addr_in == `AGRC_OFF_SCL_LOW |=> reg_rdata_out == $past(scl_q[7:0]);
	endproperty
	a_scl_rw: assert property (p_scl_rw) else $error("scale low byte readback wrong");

	property p_force_gain;
		@(posedge sys_clk_in) disable iff (rst_in)
		(mon_q == 3'h2 || mon_q == 3'h3) |=> eff_gain_out == 3'h0;
	endproperty
	a_force_gain: assert property (p_force_gain) else $error("gain not forced to unity");

	property p_restore_gain;
		@(posedge sys_clk_in) disable iff (rst_in)
		(mon_q == 3'h0 || mon_q == 3'h1) |=> eff_gain_out == $past(ctrl_q.gain_select);
	endproperty
	a_restore_gain: assert property (p_restore_gain) else $error("gain not restored");

	property p_subtract;
		@(posedge sys_clk_in) disable iff (rst_in)
		st_q == agrc_pkg::AGRC_IDLE && amp_valid && !reg_wr_in
			|=> diff_q == $signed({$past(amp[23]), $past(amp)}) - $signed({ofs_q[23], ofs_q});
	endproperty
	a_subtract: assert property (p_subtract) else $error("offset not subtracted");

	property p_unity;
		@(posedge sys_clk_in) disable iff (rst_in)
		st_q == agrc_pkg::AGRC_MUL && scl_q == 24'h400000 && diff_q <= 25'sh7FFFFF && diff_q >= -25'sh800000
			|=> result_valid_out && result_out == $past(diff_q[23:0]);
	endproperty
	a_unity: assert property (p_unity) else $error("unity scale changed result");

	property p_latency;
		@(posedge sys_clk_in) disable iff (rst_in)
		st_q == agrc_pkg::AGRC_IDLE && amp_valid |=> ##1 result_valid_out;
	endproperty
	a_latency: assert property (p_latency) else $error("result not produced two cycles after sample");

	property p_top_rate;
		@(posedge sys_clk_in) disable iff (rst_in)
		ctrl_q.output_rate_select >= 4'h9 |-> u_rate.period == 32'(CLK_HZ / 2000);
	endproperty
	a_top_rate: assert property (p_top_rate) else $error("codes 9-15 not top rate");

	property p_rate8;
		@(posedge sys_clk_in) disable iff (rst_in)
		ctrl_q.output_rate_select == 4'h8 |-> u_rate.period == 32'(CLK_HZ / 1000);
	endproperty
	a_rate8: assert property (p_rate8) else $error("code 8 not 1000 per second");

endmodule : agrc_regs

/* testbench/agrc_regs_test.sv */
// Self-checking bench for the gain, rate and calibration register bank
`timescale 1ns/1ps
`include "agrc_consts.svh"

module agrc_regs_test;

	localparam int CLK_HZ = 64000;
	localparam int rate_tab [16] = '{5, 10, 20, 40, 80, 160, 320, 640, 1000,
		2000, 2000, 2000, 2000, 2000, 2000, 2000};

	logic                    sys_clk;
	logic                    rst;
	logic [`AGRC_ADDR_W-1:0] addr;
	logic [7:0]              wdata;
	logic                    wr;
	logic                    rd;
	logic [7:0]              rdata;
	logic                    raw_valid;
	logic [23:0]             raw;
	logic [2:0]              eff_gain;
	logic                    tick;
	logic                    res_valid;
	logic [23:0]             res;
	int                      err_count;
	int                      n_compared;
	int                      n;

	agrc_regs #(.CLK_HZ(CLK_HZ)) uut (
		.sys_clk_in       (sys_clk),
		.rst_in           (rst),
		.reg_addr_in      (addr),
		.reg_wdata_in     (wdata),
		.reg_wr_in        (wr),
		.reg_rd_in        (rd),
		.reg_rdata_out    (rdata),
		.raw_valid_in     (raw_valid),
		.raw_in           (raw),
		.eff_gain_out     (eff_gain),
		.sample_tick_out  (tick),
		.result_valid_out (res_valid),
		.result_out       (res)
	);

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic test_done();
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done

	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge sys_clk);
		wr    <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [3:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge sys_clk);
		rd   <= 1'b0;
		#1;
		check({16'h0000, rdata}, {16'h0000, exp});
	endtask : reg_read

	// Write then read back at once, with no idle cycle between the strobes
	task automatic wr_rd(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge sys_clk);
		wr    <= 1'b0;
		rd    <= 1'b1;
		@(posedge sys_clk);
		rd    <= 1'b0;
		#1;
		check({16'h0000, rdata}, {16'h0000, d});
	endtask : wr_rd

	task automatic set_word(input logic [3:0] base, input logic [23:0] w);
		reg_write(base, w[7:0]);
		reg_write(base + 4'h1, w[15:8]);
		reg_write(base + 4'h2, w[23:16]);
	endtask : set_word

	task automatic check_word(input logic [3:0] base, input logic [23:0] w);
		reg_read(base, w[7:0]);
		reg_read(base + 4'h1, w[15:8]);
		reg_read(base + 4'h2, w[23:16]);
	endtask : check_word

	task automatic check_resets();
		reg_read(`AGRC_OFF_GAIN_RATE, 8'h00);
		check({21'h0, eff_gain}, 24'h0);
		reg_read(`AGRC_OFF_MONITOR, 8'h00);
		check_word(`AGRC_OFF_OFS_LOW, 24'h000000);
		check_word(`AGRC_OFF_SCL_LOW, 24'h400000);
	endtask : check_resets

	function automatic logic [23:0] sat24(input longint v);
		if (v > 64'sd8388607)
			return 24'h7FFFFF;
		if (v < -64'sd8388608)
			return 24'h800000;
		return v[23:0];
	endfunction : sat24

	// Gain, then offset subtraction, then scale over 400000h
	function automatic logic [23:0] model(input logic [23:0] v, input int g, input logic [23:0] ofs,
		input logic [23:0] scl);
		longint a;
		a = longint'($signed(sat24(longint'($signed(v)) <<< g)));
		a = a - longint'($signed(ofs));
		a = (a * longint'(scl)) >>> 22;
		return sat24(a);
	endfunction : model

	task automatic run_case(input logic [2:0] g, input logic [23:0] ofs, input logic [23:0] scl,
		input logic [23:0] v, input logic [2:0] mon);
		logic [23:0] exp;
		exp = model(v, mon[1] ? 0 : int'(g), ofs, scl);
		reg_write(`AGRC_OFF_GAIN_RATE, {1'b0, g, 4'h0});
		reg_write(`AGRC_OFF_MONITOR, {5'h00, mon});
		set_word(`AGRC_OFF_OFS_LOW, ofs);
		set_word(`AGRC_OFF_SCL_LOW, scl);
		@(posedge sys_clk);
		raw       <= v;
		raw_valid <= 1'b1;
		@(posedge sys_clk);
		raw_valid <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		check({23'h0, res_valid}, 24'h1);
		check(res, exp);
		@(posedge sys_clk);
		#1;
		check({23'h0, res_valid}, 24'h0);
		check(res, exp);
	endtask : run_case

	// Cycles up to and including the next sample strobe
	task automatic measure(output int cnt);
		cnt = 0;
		do
		begin
			@(posedge sys_clk);
			#1;
			cnt++;
		end
		while (tick !== 1'b1 && cnt < 26000);
	endtask : measure

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#1000000;
		err_count++;
		$display("ERROR at %0t: watchdog expired", $time);
		test_done();
	end

	initial
	begin
		rst        = 1'b1;
		addr       = 4'h0;
		wdata      = 8'h00;
		wr         = 1'b0;
		rd         = 1'b0;
		raw_valid  = 1'b0;
		raw        = 24'h000000;
		err_count  = 0;
		n_compared = 0;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		check_resets();
		reg_write(4'hF, 8'hFF);
		reg_read(4'hF, 8'h00);
		reg_read(4'h0, 8'h00);
		for (int g = 0; g < 8; g++)
		begin
			reg_write(`AGRC_OFF_GAIN_RATE, {1'b1, 3'(g), 4'hA});
			reg_read(`AGRC_OFF_GAIN_RATE, {1'b0, 3'(g), 4'hA});
			check({21'h0, eff_gain}, 24'(g));
		end
		reg_write(`AGRC_OFF_GAIN_RATE, 8'h5A);
		foreach (rate_tab[i])
		begin
			reg_write(`AGRC_OFF_MONITOR, {5'h00, 3'(i % 4 ^ 2)});
			reg_read(`AGRC_OFF_GAIN_RATE, 8'h5A);
			reg_read(`AGRC_OFF_MONITOR, {5'h00, 3'(i % 4 ^ 2)});
			check({21'h0, eff_gain}, ((i % 4 ^ 2) > 1) ? 24'h0 : 24'h5);
		end
		set_word(`AGRC_OFF_OFS_LOW, 24'hA5C35A);
		check_word(`AGRC_OFF_OFS_LOW, 24'hA5C35A);
		set_word(`AGRC_OFF_SCL_LOW, 24'h5AC3A5);
		check_word(`AGRC_OFF_SCL_LOW, 24'h5AC3A5);
		wr_rd(`AGRC_OFF_OFS_HIGH, 8'h3C);
		wr_rd(`AGRC_OFF_SCL_HIGH, 8'hC3);
		run_case(3'h0, 24'h000000, 24'h400000, 24'h001234, 3'h0);
		run_case(3'h0, 24'h000100, 24'h400000, 24'h001234, 3'h0);
		run_case(3'h0, 24'hFFFF00, 24'h400000, 24'hFFF000, 3'h0);
		run_case(3'h0, 24'h000080, 24'h400000, 24'h000400, 3'h1);
		run_case(3'h0, 24'h000100, 24'h200000, 24'h004000, 3'h0);
		run_case(3'h0, 24'h000000, 24'h800000, 24'h123456, 3'h0);
		run_case(3'h2, 24'h000010, 24'h400000, 24'h000321, 3'h0);
		run_case(3'h7, 24'h000000, 24'h400000, 24'h100000, 3'h0);
		run_case(3'h7, 24'h000000, 24'h400000, 24'h100000, 3'h3);
		run_case(3'h7, 24'h000000, 24'h400000, 24'h000003, 3'h0);
		// Fast to slow, so a running count never overshoots the new period
		for (int c = 15; c >= 0; c--)
		begin
			reg_write(`AGRC_OFF_GAIN_RATE, {4'h0, 4'(c)});
			measure(n);
			measure(n);
			check(24'(n), 24'(CLK_HZ / rate_tab[c]));
		end
		// Leave every register off its reset value so the second reset has work to do
		reg_write(`AGRC_OFF_GAIN_RATE, 8'h5A);
		reg_write(`AGRC_OFF_MONITOR, 8'h01);
		set_word(`AGRC_OFF_OFS_LOW, 24'h123456);
		set_word(`AGRC_OFF_SCL_LOW, 24'h0F0F0F);
		reg_read(`AGRC_OFF_MONITOR, 8'h01);
		check({21'h0, eff_gain}, 24'h5);
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		check_resets();
		test_done();
	end

endmodule : agrc_regs_test
